// ===== pdlm_top.sv
// Clock synthesizer digital side: reference, feedback and post dividers,
// frequency-comparing lock detector with hysteresis, and lock-change interrupt.
// Assumes the oscillator loop, crystal and 1 MHz clocks arrive as levels
// synchronous to mclk and slower than half its rate.
//
// Added by the designer: the address map and strobed register access.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Feedback clock is the oscillator loop clock divided by feedback_divider plus one.
// - Divided reference is 1 MHz or crystal source divided by reference_divider plus one.
// - Lock is judged by comparing feedback and reference edge counts per window.
// - The in-tolerance flag is read-only; writes to it do nothing.
// - Flag sets inside lock tolerance and clears only outside wider unlock tolerance or on reference loss.
// - With enable set, every flag change raises an interrupt request.
// - Lost reference prevents lock and drops an existing lock.
// - After reset the reference comes from the internal 1 MHz source and the bus clock from the synthesized path.
module pdlm_top #(
    parameter int unsigned REF_LOSS_CYCLES = pdlm_pkg::REF_LOSS_CYC
) (
    input  wire logic        mclk,
    input  wire logic        srst,
    input  wire logic [3:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output var  logic [31:0] rdata,
    input  wire logic        internal_1mhz_source,
    input  wire logic        crystal_oscillator_clock,
    input  wire logic        oscillator_loop_clock,
    output var  logic        divided_reference_clock,
    output var  logic        feedback_clock,
    output var  logic        synthesized_clock,
    output var  logic        bus_clock,
    output var  logic [1:0]  reference_range_select,
    output var  logic [1:0]  loop_range_select,
    output var  logic        irq
);
    // Control registers. The lock and reference-ok flags are written only by the detector.
    logic       src_crystal_r;
    logic       sys_sel_pll_r;
    logic [1:0] ref_rng_r;
    logic [1:0] loop_rng_r;
    logic [3:0] reference_divider_r;
    logic [5:0] feedback_divider_r;
    logic [4:0] post_divider_r;
    logic       lock_r;
    logic       ref_ok_r;
    logic       irq_st_r;
    logic       tolerance_change_irq_enable_r;

    // Address decode, shared by the write strobes and the read mux.
    wire hit_ctrl    = addr == pdlm_pkg::ADDR_CTRL;
    wire hit_div     = addr == pdlm_pkg::ADDR_DIV;
    wire hit_status  = addr == pdlm_pkg::ADDR_STATUS;
    wire hit_irq_st  = addr == pdlm_pkg::ADDR_IRQ_ST;
    wire hit_irq_en  = addr == pdlm_pkg::ADDR_IRQ_EN;
    wire hit_irq_clr = addr == pdlm_pkg::ADDR_IRQ_CLR;
    // Status words have no write decode, so software cannot disturb the flags.
    wire wr_ctrl     = wr & hit_ctrl;
    wire wr_div      = wr & hit_div;
    wire wr_en       = wr & hit_irq_en;
    wire wr_clr      = wr & hit_irq_clr;

    // Source edges.
    wire src_lvl = src_crystal_r ? crystal_oscillator_clock : internal_1mhz_source;
    wire src_rise;
    wire loop_rise;
    // Switching the source mid-window spoils one judgement at most; the next
    // window starts clean from the following divided-reference tick.
    pdlm_edge u_src_edge (
        .mclk (mclk),
        .srst (srst),
        .lvl  (src_lvl),
        .rise (src_rise)
    );
    pdlm_edge u_loop_edge (
        .mclk (mclk),
        .srst (srst),
        .lvl  (oscillator_loop_clock),
        .rise (loop_rise)
    );

    wire ref_tick;
    wire ref_lvl;
    wire fb_tick;
    wire fb_lvl;
    wire post_tick;
    wire post_lvl;
    // All dividers count edge ticks instead of running on divided clocks, so
    // every flop stays in the mclk domain and no clock is gated or muxed.
    pdlm_div #(.W(4)) u_ref_div (
        .mclk     (mclk),
        .srst     (srst),
        .in_tick  (src_rise),
        .div      (reference_divider_r),
        .out_tick (ref_tick),
        .out_lvl  (ref_lvl)
    );
    pdlm_div #(.W(6)) u_fb_div (
        .mclk     (mclk),
        .srst     (srst),
        .in_tick  (loop_rise),
        .div      (feedback_divider_r),
        .out_tick (fb_tick),
        .out_lvl  (fb_lvl)
    );
    pdlm_div #(.W(5)) u_post_div (
        .mclk     (mclk),
        .srst     (srst),
        .in_tick  (loop_rise),
        .div      (post_divider_r),
        .out_tick (post_tick),
        .out_lvl  (post_lvl)
    );

    // With the synthesizer selected, bus clock toggles on each synthesized rising edge; else it toggles on each loop-clock rise, halving the loop clock.
    logic bus_div_r;
    wire  bus_src_tick = sys_sel_pll_r ? post_tick : loop_rise;

    // Lock detector: count feedback edges over a window of reference edges.
    // A slow reference lengthens every window, so the first lock takes at least
    // one whole window plus the judge cycle.
    pdlm_pkg::pdlm_state_t state_r;
    pdlm_pkg::pdlm_state_t state_nxt;
    logic [3:0]  ref_cnt_r;
    logic [7:0]  fb_cnt_r;
    logic [15:0] loss_cnt_r;

    // Unsigned distance; both operands are counts, so no sign is needed.
    function automatic logic [7:0] absdiff(input logic [7:0] a, input logic [7:0] b);
        absdiff = (a > b) ? a - b : b - a;
    endfunction : absdiff

    // Expected feedback edges equals window length in a locked loop.
    wire [7:0] err       = absdiff(fb_cnt_r, {4'h0, pdlm_pkg::WINDOW_REF_EDGES});
    wire       in_lock   = err <= {4'h0, pdlm_pkg::LOCK_TOL};
    wire       out_unl   = err > {4'h0, pdlm_pkg::UNLOCK_TOL};
    wire       ref_lost  = loss_cnt_r >= REF_LOSS_CYCLES[15:0];
    wire       window_end = ref_tick & (ref_cnt_r == pdlm_pkg::WINDOW_REF_EDGES - 4'h1);
    wire       fb_sat    = fb_cnt_r == 8'hff;

    // Idle waits for a reference tick so that the first window is a whole one.
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            pdlm_pkg::PDLM_IDLE: begin
                if (ref_tick) begin
                    state_nxt = pdlm_pkg::PDLM_COUNT;
                end
            end
            pdlm_pkg::PDLM_COUNT: begin
                if (ref_lost) begin
                    state_nxt = pdlm_pkg::PDLM_IDLE;
                end else if (window_end) begin
                    state_nxt = pdlm_pkg::PDLM_JUDGE;
                end
            end
            pdlm_pkg::PDLM_JUDGE: begin
                state_nxt = pdlm_pkg::PDLM_COUNT;
            end
            default: begin
                state_nxt = pdlm_pkg::PDLM_IDLE;
            end
        endcase
    end

    // A stopped reference makes the comparison meaningless, so the loss counter
    // overrides the window result and drops the flag at once.
    // Hysteresis: set within the lock band, clear only beyond the unlock band.
    wire judge    = state_r == pdlm_pkg::PDLM_JUDGE;
    wire lock_nxt = ref_lost ? 1'b0 :
                    judge    ? (lock_r ? ~out_unl : in_lock) :
                               lock_r;
    wire lock_chg = lock_nxt ^ lock_r;

    always_ff @(posedge mclk) begin
        if (srst) begin
            state_r    <= pdlm_pkg::PDLM_IDLE;
            ref_cnt_r  <= 4'h0;
            fb_cnt_r   <= 8'h00;
            loss_cnt_r <= 16'h0000;
            lock_r     <= 1'b0;
            ref_ok_r   <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            lock_r   <= lock_nxt;
            ref_ok_r <= ~ref_lost;
            // Missing reference edges let the counter climb until it holds at the loss limit, so loss is seen in bounded time.
            loss_cnt_r <= ref_tick ? 16'h0000 : (ref_lost ? loss_cnt_r : loss_cnt_r + 16'h0001);
            if (state_r != pdlm_pkg::PDLM_COUNT) begin
                ref_cnt_r <= 4'h0;
                fb_cnt_r  <= {7'h00, fb_tick};
            end else begin
                if (ref_tick) begin
                    ref_cnt_r <= ref_cnt_r + 4'h1;
                end
                if (fb_tick & ~fb_sat) begin
                    fb_cnt_r <= fb_cnt_r + 8'h01;
                end
            end
        end
    end

    // Registers written by software; the lock flag has no write path.
    always_ff @(posedge mclk) begin
        if (srst) begin
            src_crystal_r <= 1'b0;
            sys_sel_pll_r <= 1'b1;
            ref_rng_r     <= pdlm_pkg::REF_RNG_RST;
            loop_rng_r    <= pdlm_pkg::LOOP_RNG_RST;
        end else if (wr_ctrl) begin
            src_crystal_r <= wdata[pdlm_pkg::CTRL_SRC_BIT];
            sys_sel_pll_r <= wdata[pdlm_pkg::CTRL_SYSSEL_BIT];
            ref_rng_r     <= wdata[pdlm_pkg::CTRL_REFRNG_LSB +: 2];
            loop_rng_r    <= wdata[pdlm_pkg::CTRL_LOOPRNG_LSB +: 2];
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            reference_divider_r <= pdlm_pkg::REF_DIV_RST;
            feedback_divider_r  <= pdlm_pkg::FB_DIV_RST;
            post_divider_r      <= pdlm_pkg::POST_DIV_RST;
        end else if (wr_div) begin
            reference_divider_r <= wdata[pdlm_pkg::DIV_REF_LSB +: 4];
            feedback_divider_r  <= wdata[pdlm_pkg::DIV_FB_LSB +: 6];
            post_divider_r      <= wdata[pdlm_pkg::DIV_POST_LSB +: 5];
        end
    end

    // Sticky status: a new change in the clear cycle wins over the clear.
    // The interrupt pin lags the status bit by one cycle because it is registered.
    always_ff @(posedge mclk) begin
        if (srst) begin
            irq_st_r                      <= 1'b0;
            tolerance_change_irq_enable_r <= 1'b0;
        end else begin
            irq_st_r <= lock_chg | (irq_st_r & ~(wr_clr & wdata[pdlm_pkg::IRQ_LOCK_BIT]));
            if (wr_en) begin
                tolerance_change_irq_enable_r <= wdata[pdlm_pkg::IRQ_LOCK_BIT];
            end
        end
    end

    // Read mux. Read data is zero outside the answer cycle, so several slaves
    // can share one return bus through a plain OR.
    wire [31:0] ctrl_rd = {24'h000000, loop_rng_r, ref_rng_r, 2'h0, sys_sel_pll_r, src_crystal_r};
    wire [31:0] div_rd  = {11'h000, post_divider_r, 2'h0, feedback_divider_r,
                           4'h0, reference_divider_r};
    wire [31:0] st_rd   = {30'h00000000, ref_ok_r, lock_r};
    wire [31:0] rd_mux  = hit_ctrl   ? ctrl_rd :
                          hit_div    ? div_rd :
                          hit_status ? st_rd :
                          hit_irq_st ? {31'h00000000, irq_st_r} :
                          hit_irq_en ?
                              {31'h00000000, tolerance_change_irq_enable_r} :
                          32'h00000000;

    // Range outputs reset to the control defaults, so the analog loop starts
    // with a sane bandwidth before software writes the control word.
    always_ff @(posedge mclk) begin
        if (srst) begin
            rdata                  <= 32'h00000000;
            reference_range_select <= pdlm_pkg::REF_RNG_RST;
            loop_range_select      <= pdlm_pkg::LOOP_RNG_RST;
            irq                    <= 1'b0;
        end else begin
            rdata                  <= rd ? rd_mux : 32'h00000000;
            reference_range_select <= ref_rng_r;
            loop_range_select      <= loop_rng_r;
            irq                    <= irq_st_r & tolerance_change_irq_enable_r;
        end
    end

    // Every clock output leaves through a flop, so each edge is one mclk late.
    always_ff @(posedge mclk) begin
        if (srst) begin
            divided_reference_clock <= 1'b0;
            feedback_clock          <= 1'b0;
            synthesized_clock       <= 1'b0;
            bus_div_r               <= 1'b0;
            bus_clock               <= 1'b0;
        end else begin
            divided_reference_clock <= ref_lvl;
            feedback_clock          <= fb_lvl;
            synthesized_clock       <= post_lvl;
            bus_div_r               <= bus_src_tick ? ~bus_div_r : bus_div_r;
            bus_clock               <= bus_div_r;
        end
    end
endmodule : pdlm_top
`default_nettype wire

// ===== pdlm_pkg.sv
// Package for the clock synthesizer divider and lock monitor block.
// Assumes a single 100 MHz register clock; all other clocks are sampled as levels.
package pdlm_pkg;
    localparam int unsigned MCLK_PERIOD_NS = 10;
    localparam logic [3:0] ADDR_CTRL    = 4'h0;
    localparam logic [3:0] ADDR_DIV     = 4'h1;
    localparam logic [3:0] ADDR_STATUS  = 4'h2;
    localparam logic [3:0] ADDR_IRQ_ST  = 4'h3;
    localparam logic [3:0] ADDR_IRQ_EN  = 4'h4;
    localparam logic [3:0] ADDR_IRQ_CLR = 4'h5;
    // CTRL fields.
    localparam int unsigned CTRL_SRC_BIT   = 0;
    localparam int unsigned CTRL_SYSSEL_BIT = 1;
    localparam int unsigned CTRL_REFRNG_LSB = 4;
    localparam int unsigned CTRL_LOOPRNG_LSB = 6;
    // DIV fields.
    localparam int unsigned DIV_REF_LSB  = 0;
    localparam int unsigned DIV_FB_LSB   = 8;
    localparam int unsigned DIV_POST_LSB = 16;
    // Reset values: 1 MHz internal source, feedback 0x18, post 0x00.
    localparam logic [3:0] REF_DIV_RST  = 4'h0;
    localparam logic [5:0] FB_DIV_RST   = 6'h18;
    localparam logic [4:0] POST_DIV_RST = 5'h00;
    localparam logic [1:0] REF_RNG_RST  = 2'h0;
    localparam logic [1:0] LOOP_RNG_RST = 2'h1;
    // Status and interrupt bits.
    localparam int unsigned ST_LOCK_BIT  = 0;
    localparam int unsigned ST_REFOK_BIT = 1;
    localparam int unsigned IRQ_LOCK_BIT = 0;
    // Lock window in reference periods, and tolerances in feedback counts.
    localparam logic [3:0] WINDOW_REF_EDGES = 4'h8;
    localparam logic [3:0] LOCK_TOL   = 4'h1;
    localparam logic [3:0] UNLOCK_TOL = 4'h3;
    // Reference loss: no divided-reference tick seen for this many mclk cycles.
    localparam int unsigned REF_LOSS_NS = 20000;
    localparam int unsigned REF_LOSS_CYC = REF_LOSS_NS / MCLK_PERIOD_NS;
    typedef enum logic [1:0] {
        PDLM_IDLE   = 2'b00,
        PDLM_COUNT  = 2'b01,
        PDLM_JUDGE  = 2'b10
    } pdlm_state_t;
endpackage : pdlm_pkg

// ===== pdlm_edge.sv
// Rising-edge detector for a level-sampled clock.
// Assumes the input is synchronous to mclk.
`timescale 1ns/1ns
`default_nettype none
module pdlm_edge (
    input  wire logic mclk,
    input  wire logic srst,
    input  wire logic lvl,
    output var  logic rise
);
    logic lvl_r;
    always_ff @(posedge mclk) begin
        if (srst) begin
            lvl_r <= 1'b0;
        end else begin
            lvl_r <= lvl;
        end
    end
    assign rise = lvl & ~lvl_r;
endmodule : pdlm_edge
`default_nettype wire

// ===== pdlm_div.sv
// Programmable divider: one output toggle-free pulse train of rate in/(div+1).
// Assumes in_tick is a one-cycle pulse per source edge.
`timescale 1ns/1ns
`default_nettype none
module pdlm_div #(
    parameter int unsigned W = 6
) (
    input  wire logic         mclk,
    input  wire logic         srst,
    input  wire logic         in_tick,
    input  wire logic [W-1:0] div,
    output var  logic         out_tick,
    output var  logic         out_lvl
);
    logic [W-1:0] cnt_r;
    wire          wrap = (cnt_r >= div);
    always_ff @(posedge mclk) begin
        if (srst) begin
            cnt_r    <= '0;
            out_tick <= 1'b0;
            out_lvl  <= 1'b0;
        end else begin
            out_tick <= in_tick & wrap;
            if (in_tick) begin
                cnt_r <= wrap ? '0 : cnt_r + 1'b1;
            end
            // A divide-by-one output has no midpoint, so it mirrors the source ticks.
            if (div == '0) begin
                out_lvl <= in_tick;
            end else if (in_tick & (wrap | (cnt_r == (div >> 1)))) begin
                out_lvl <= wrap;
            end
        end
    end
endmodule : pdlm_div
`default_nettype wire

// ===== pdlm_top_props.sv
// Concurrent checks on the register port, range outputs and interrupt of pdlm_top.
// Assumes one mclk domain and a synchronous active-high srst.
`timescale 1ns/1ns
`default_nettype none
module pdlm_top_props #(
    parameter int unsigned REF_LOSS_CYCLES = 2000
) (
    input wire logic        mclk,
    input wire logic        srst,
    input wire logic [3:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [31:0] rdata,
    input wire logic [1:0]  reference_range_select,
    input wire logic [1:0]  loop_range_select,
    input wire logic        irq
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);
    a_reset_values: assert property ($fell(srst) |-> irq == 1'b0 && rdata == 32'h0
        && reference_range_select == pdlm_pkg::REF_RNG_RST
        && loop_range_select == pdlm_pkg::LOOP_RNG_RST) else $error("bad values after reset");
    a_rdata_idle: assert property (!rd |=> rdata == 32'h0)
        else $error("read data outside read slot");
    a_range_write: assert property (wr && addr == pdlm_pkg::ADDR_CTRL |-> ##2
        reference_range_select == $past(wdata[5:4], 2)
        && loop_range_select == $past(wdata[7:6], 2))
        else $error("range outputs do not follow control write");
    a_ctrl_readback: assert property (rd && addr == pdlm_pkg::ADDR_CTRL |=>
        rdata[7:4] == {loop_range_select, reference_range_select}) else $error("ctrl readback");
    a_unmapped_zero: assert property (rd && addr > 4'h5 |=> rdata == 32'h0)
        else $error("unmapped read not zero");
    a_irq_masked: assert property (wr && addr == pdlm_pkg::ADDR_IRQ_EN && !wdata[0]
        |-> ##2 !irq) else $error("irq high while disabled");
    a_div_readback: assert property (wr && addr == pdlm_pkg::ADDR_DIV ##2
        rd && addr == pdlm_pkg::ADDR_DIV |=> {rdata[20:16], rdata[13:8], rdata[3:0]}
        == {$past(wdata[20:16], 3), $past(wdata[13:8], 3), $past(wdata[3:0], 3)})
        else $error("divider readback");
    a_lock_needs_ref: assert property (rd && addr == pdlm_pkg::ADDR_STATUS |=>
        !rdata[0] || rdata[1]) else $error("lock without reference");
    c_locked: cover property (rd && addr == pdlm_pkg::ADDR_STATUS ##1 rdata[0]);
    c_irq_up: cover property ($rose(irq));
    c_irq_down: cover property ($fell(irq));
endmodule : pdlm_top_props
bind pdlm_top pdlm_top_props #(.REF_LOSS_CYCLES(REF_LOSS_CYCLES)) u_props (.mclk(mclk),
    .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
    .reference_range_select(reference_range_select), .loop_range_select(loop_range_select));
`default_nettype wire

// ===== pdlm_top_tb.sv
// Self-checking bench for pdlm_top: registers, division rates, lock, hysteresis, loss.
// Assumes the checker file is bound; source clocks are slow levels made here.
`timescale 1ns/1ns
`default_nettype none
module pdlm_top_tb;
    logic        mclk, srst, wr, rd, src1m, xtal, loop_in;
    logic [3:0]  addr;
    logic [31:0] wdata, rdata, rv;
    logic        ref_out, fb_out, syn_out, bus_out, irq;
    logic [1:0]  ref_rng, loop_rng;
    int          error_cnt, cmp_count, hold_ref;
    int          loop_half = 2;
    pdlm_top #(.REF_LOSS_CYCLES(200)) dut (.mclk(mclk), .srst(srst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .internal_1mhz_source(src1m),
        .crystal_oscillator_clock(xtal), .oscillator_loop_clock(loop_in),
        .divided_reference_clock(ref_out), .feedback_clock(fb_out), .synthesized_clock(syn_out),
        .bus_clock(bus_out), .reference_range_select(ref_rng), .loop_range_select(loop_rng),
        .irq(irq));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // Both reference sources are frozen together to model a lost reference; the loop clock keeps running.
    always begin
        repeat (loop_half) @(posedge mclk);
        loop_in <= ~loop_in;
    end
    always begin
        repeat (10) @(posedge mclk);
        if (hold_ref == 0) src1m <= ~src1m;
    end
    always begin
        repeat (5) @(posedge mclk);
        if (hold_ref == 0) xtal <= ~xtal;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_near(input int got, input int exp);
        cmp_count++;
        if (got < exp - 1 || got > exp + 1) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_near
    // A gap cycle after each strobe keeps every driver change one per time step.
    task automatic wreg(input logic [3:0] a, input logic [31:0] d);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
        @(posedge mclk);
    endtask : wreg
    task automatic rreg(input logic [3:0] a);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1 rv = rdata;
        @(posedge mclk);
    endtask : rreg
    task automatic wait_lock(input logic exp);
        int n;
        n = 0;
        rv = {32{~exp}};
        while (rv[0] !== exp && n < 150) begin
            rreg(pdlm_pkg::ADDR_STATUS);
            repeat (20) @(posedge mclk);
            n++;
        end
        chk({31'h0, rv[0]}, {31'h0, exp});
    endtask : wait_lock
    task automatic irq_ack(input logic exp);
        chk({31'h0, irq}, {31'h0, exp});
        rreg(pdlm_pkg::ADDR_IRQ_ST);
        chk(rv, {31'h0, exp});
        wreg(pdlm_pkg::ADDR_IRQ_CLR, 32'h1);
        repeat (3) @(posedge mclk);
        chk({31'h0, irq}, 32'h0);
    endtask : irq_ack
    task automatic t_reset();
        rreg(pdlm_pkg::ADDR_CTRL);
        chk(rv, {24'h0, pdlm_pkg::LOOP_RNG_RST, pdlm_pkg::REF_RNG_RST, 4'h2});
        rreg(pdlm_pkg::ADDR_DIV);
        chk(rv, {11'h0, pdlm_pkg::POST_DIV_RST, 2'h0, pdlm_pkg::FB_DIV_RST, 4'h0,
            pdlm_pkg::REF_DIV_RST});
        $display("test reset done");
    endtask : t_reset
    task automatic t_regs();
        wreg(pdlm_pkg::ADDR_DIV, 32'h0001_0400);
        rreg(pdlm_pkg::ADDR_DIV);
        chk(rv, 32'h0001_0400);
        wreg(pdlm_pkg::ADDR_CTRL, 32'h0000_00e2);
        // The range pins copy the control fields one flop later.
        @(posedge mclk);
        chk({28'h0, loop_rng, ref_rng}, 32'he);
        rreg(4'hf);
        chk(rv, 32'h0);
        wreg(pdlm_pkg::ADDR_STATUS, 32'h3);
        rreg(pdlm_pkg::ADDR_STATUS);
        chk({31'h0, rv[0]}, 32'h0);
        wreg(pdlm_pkg::ADDR_CTRL, 32'h0000_0042);
        $display("test regs done");
    endtask : t_regs
    task automatic t_lock_hyst();
        wreg(pdlm_pkg::ADDR_IRQ_EN, 32'h1);
        wait_lock(1'b1);
        irq_ack(1'b1);
        loop_half = 3;
        repeat (1000) @(posedge mclk);
        rreg(pdlm_pkg::ADDR_STATUS);
        chk({31'h0, rv[0]}, 32'h1);
        chk({31'h0, irq}, 32'h0);
        loop_half = 5;
        wait_lock(1'b0);
        irq_ack(1'b1);
        $display("test lock and hysteresis done");
    endtask : t_lock_hyst
    task automatic t_loss();
        loop_half = 2;
        wreg(pdlm_pkg::ADDR_IRQ_EN, 32'h0);
        wait_lock(1'b1);
        hold_ref = 1;
        wait_lock(1'b0);
        chk({31'h0, irq}, 32'h0);
        repeat (600) @(posedge mclk);
        rreg(pdlm_pkg::ADDR_STATUS);
        chk({31'h0, rv[0]}, 32'h0);
        hold_ref = 0;
        wreg(pdlm_pkg::ADDR_DIV, 32'h0001_0401);
        wreg(pdlm_pkg::ADDR_CTRL, 32'h0000_0043);
        wait_lock(1'b1);
        $display("test reference loss done");
    endtask : t_loss
    task automatic t_rates();
        int c[4];
        logic [3:0] p;
        logic [3:0] s;
        c = '{0, 0, 0, 0};
        p = 4'h0;
        repeat (800) begin
            @(posedge mclk);
            #1 s = {ref_out, fb_out, syn_out, bus_out};
            for (int i = 0; i < 4; i++) c[i] += int'(s[i] & ~p[i]);
            p = s;
        end
        chk_near(c[3], 40);
        chk_near(c[2], 40);
        chk_near(c[1], 100);
        chk_near(c[0], 50);
        // With the synthesizer deselected the bus clock halves the loop clock.
        wreg(pdlm_pkg::ADDR_CTRL, 32'h0000_0041);
        c[0] = 0;
        repeat (800) begin
            @(posedge mclk);
            #1 s[0] = bus_out;
            c[0] += int'(s[0] & ~p[0]);
            p[0] = s[0];
        end
        chk_near(c[0], 100);
        $display("test rates done");
    endtask : t_rates
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test
    initial begin
        #500000;
        error_cnt++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
        stop_test();
    end
    initial begin
        srst = 1'b1;
        {wr, rd, addr, wdata, loop_in, src1m, xtal} = '0;
        repeat (4) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        t_reset();
        t_regs();
        t_lock_hyst();
        t_loss();
        t_rates();
        stop_test();
    end
endmodule : pdlm_top_tb
`default_nettype wire
